// >>> adcavg_cfg.svh
// offsets, field positions, reset values and limits of the averaging control
`ifndef ADCAVG_CFG_SVH
`define ADCAVG_CFG_SVH
`define ADCAVG_ACC_CTRL_IDX     4'h2
`define ADCAVG_ACC_CTRL_ADDR    12'h008
`define ADCAVG_RESULT_ADDR      12'h00c
`define ADCAVG_STATUS_ADDR      12'h010
`define ADCAVG_WPROT_ADDR       12'h014
`define ADCAVG_ACC_CTRL_RST     8'h00
`define ADCAVG_SCNT_LSB         0
`define ADCAVG_SCNT_MSB         3
`define ADCAVG_SHIFT_LSB        4
`define ADCAVG_SHIFT_MSB        6
`define ADCAVG_RSVD_BIT         7
`define ADCAVG_SCNT_MAX         4'ha
`define ADCAVG_SAMPLE_W         12
`define ADCAVG_SUM_W            22
`endif

// >>> adcavg_pkg.sv
// types of the averaging control
package adcavg_pkg;
	typedef enum logic [1:0] {
		ADCAVG_IDLE = 2'b01,
		ADCAVG_ACC  = 2'b10
	} adcavg_state_t;
endpackage

// >>> adcavg_top.sv
// sample accumulation and averaging control with apb registers
//
// Notes on behaviour
// - codes 0 to 0xa sum 1 to 1024 samples in powers of two, codes 0xb to 0xf are reserved.
// - the sample count sits in bits 3:0 of the control register and sets the accumulation length.
// - bits 6:4 give a power-of-two division coefficient for the sum.
// - the final value is placed in the result register for software to read.
// - bit 7 of the control register is reserved, reads zero and should be written zero.
`timescale 1ns/1ps
`include "adcavg_cfg.svh"
module adcavg_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sample_valid,
	input  wire logic [11:0] sample_data,
	output logic             result_valid
);

	////////////////////////////////////////////////////////////////////
	// register state
	logic [6:0]                  acc_ctrl;
	logic [6:0]                  next_acc_ctrl;
	logic                        wprot;
	logic                        next_wprot;
	logic                        wr_ok;
	logic                        rd_ok;
	logic                        acc_wr;
	logic                        rsvd_code;

	assign pready    = 1'b1;
	assign wr_ok     = psel && penable && pwrite;
	assign rd_ok     = psel && penable && !pwrite;
	assign rsvd_code = (acc_ctrl[`ADCAVG_SCNT_MSB:`ADCAVG_SCNT_LSB] > `ADCAVG_SCNT_MAX);
	assign acc_wr    = wr_ok && (paddr == `ADCAVG_ACC_CTRL_ADDR) && !wprot;

	// next register values, bit 7 is never stored
	always_comb begin
		next_acc_ctrl = acc_ctrl;
		next_wprot    = wprot;
		if (acc_wr) begin
			next_acc_ctrl = pwdata[6:0];
		end
		if (wr_ok && paddr == `ADCAVG_WPROT_ADDR) begin
			next_wprot = pwdata[0];
		end
	end

	// register flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_ctrl <= 7'(`ADCAVG_ACC_CTRL_RST);
			wprot    <= 1'b0;
		end else begin
			acc_ctrl <= next_acc_ctrl;
			wprot    <= next_wprot;
		end
	end

	////////////////////////////////////////////////////////////////////
	// accumulator
	adcavg_pkg::adcavg_state_t   state;
	adcavg_pkg::adcavg_state_t   next_state;
	logic [`ADCAVG_SUM_W-1:0]    sum;
	logic [`ADCAVG_SUM_W-1:0]    next_sum;
	logic [10:0]                 cnt;
	logic [10:0]                 next_cnt;
	logic [`ADCAVG_SUM_W-1:0]    result;
	logic [`ADCAVG_SUM_W-1:0]    next_result;
	logic                        next_result_valid;
	logic [10:0]                 target;
	logic [`ADCAVG_SUM_W-1:0]    sum_in;
	logic [`ADCAVG_SUM_W-1:0]    shifted;

	assign target  = 11'h001 << acc_ctrl[`ADCAVG_SCNT_MSB:`ADCAVG_SCNT_LSB];
	assign sum_in  = sum + {10'h000, sample_data};
	assign shifted = sum_in >> acc_ctrl[`ADCAVG_SHIFT_MSB:`ADCAVG_SHIFT_LSB];

	// sum samples; a control write ends the run and returns to idle
	always_comb begin
		next_state        = state;
		next_sum          = sum;
		next_cnt          = cnt;
		next_result       = result;
		next_result_valid = 1'b0;
		case (state)
			adcavg_pkg::ADCAVG_IDLE: begin
				next_sum = '0;
				next_cnt = 11'h000;
				if (sample_valid && !rsvd_code && !acc_wr) begin
					if (target == 11'h001) begin
						next_result       = shifted;
						next_result_valid = 1'b1;
					end else begin
						next_sum   = sum_in;
						next_cnt   = 11'h001;
						next_state = adcavg_pkg::ADCAVG_ACC;
					end
				end
			end
			adcavg_pkg::ADCAVG_ACC: begin
				if (acc_wr || rsvd_code) begin
					next_state = adcavg_pkg::ADCAVG_IDLE;
				end else if (sample_valid) begin
					if (cnt + 11'h001 == target) begin
						next_result       = shifted;
						next_result_valid = 1'b1;
						next_state        = adcavg_pkg::ADCAVG_IDLE;
					end else begin
						next_sum = sum_in;
						next_cnt = cnt + 11'h001;
					end
				end
			end
			default: begin
				next_state = adcavg_pkg::ADCAVG_IDLE;
			end
		endcase
	end

	// accumulator flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state        <= adcavg_pkg::ADCAVG_IDLE;
			sum          <= '0;
			cnt          <= 11'h000;
			result       <= '0;
			result_valid <= 1'b0;
		end else begin
			state        <= next_state;
			sum          <= next_sum;
			cnt          <= next_cnt;
			result       <= next_result;
			result_valid <= next_result_valid;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read mux and error answer
	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		if (rd_ok || wr_ok) begin
			case (paddr)
				`ADCAVG_ACC_CTRL_ADDR: prdata = {25'h0, acc_ctrl};
				`ADCAVG_RESULT_ADDR:   prdata = {10'h000, result};
				`ADCAVG_STATUS_ADDR:   prdata = {29'h0, rsvd_code,
					state == adcavg_pkg::ADCAVG_ACC, wprot};
				`ADCAVG_WPROT_ADDR:    prdata = {31'h0, wprot};
				default:               pslverr = 1'b1;
			endcase
			if (!rd_ok) begin
				prdata = 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	// reserved top bit of the control word always reads zero
	a_rsvd_bit_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rd_ok && paddr == `ADCAVG_ACC_CTRL_ADDR |-> prdata[7] == 1'b0)
		else $error("reserved bit reads nonzero");

	// control read shows both fields in place
	a_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
		rd_ok && paddr == `ADCAVG_ACC_CTRL_ADDR |-> prdata == {25'h0, acc_ctrl})
		else $error("control read wrong");

	// an accepted write lands at the access edge
	a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		acc_wr |=> acc_ctrl == $past(pwdata[6:0]))
		else $error("control write not stored");

	// protection freezes the control word
	a_prot_hold: assert property (@(posedge pclk) disable iff (!presetn)
		wprot && !acc_wr |=> $stable(acc_ctrl))
		else $error("protected control changed");

	// protect bit follows its own write
	a_wprot_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && paddr == `ADCAVG_WPROT_ADDR |=> wprot == $past(pwdata[0]))
		else $error("protect write not stored");

	// one sample with no shift passes straight through
	a_single_pass: assert property (@(posedge pclk) disable iff (!presetn)
		state == adcavg_pkg::ADCAVG_IDLE && sample_valid && !acc_wr && !rsvd_code
		&& acc_ctrl == 7'h00 |=> result_valid && result == {10'h000, $past(sample_data)})
		else $error("single sample result wrong");

	// stored result is the full sum shifted right
	a_shift_value: assert property (@(posedge pclk) disable iff (!presetn)
		next_result_valid |=> result == ($past(sum_in) >> $past(acc_ctrl[6:4])))
		else $error("result shift wrong");

	// zero shift keeps the plain sum
	a_shift_zero: assert property (@(posedge pclk) disable iff (!presetn)
		next_result_valid && acc_ctrl[6:4] == 3'h0 |=> result == $past(sum_in))
		else $error("unshifted result wrong");

	// reserved counts never yield a result
	a_rsvd_code_idle: assert property (@(posedge pclk) disable iff (!presetn)
		rsvd_code |=> !result_valid)
		else $error("reserved code produced result");

	// reserved counts drop any run in progress
	a_rsvd_abort: assert property (@(posedge pclk) disable iff (!presetn)
		rsvd_code |=> state == adcavg_pkg::ADCAVG_IDLE)
		else $error("reserved code kept accumulating");

	// legal codes ask for at most 1024 samples
	a_target_range: assert property (@(posedge pclk) disable iff (!presetn)
		!rsvd_code |-> target <= 11'h400)
		else $error("sample target out of range");

	// count stays below the run length
	a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
		state == adcavg_pkg::ADCAVG_ACC |-> cnt < target)
		else $error("count passed target");

	// gaps between samples leave the run untouched
	a_cnt_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state == adcavg_pkg::ADCAVG_ACC && !sample_valid && !acc_wr && !rsvd_code
		|=> $stable(cnt) && $stable(sum))
		else $error("run moved without sample");

	// each middle sample adds one to the count
	a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
		state == adcavg_pkg::ADCAVG_ACC && sample_valid && !acc_wr && !rsvd_code
		&& (cnt + 11'h001 != target) |=> cnt == $past(cnt) + 11'h001)
		else $error("count step wrong");

	// a control write ends a run in progress
	a_write_abort: assert property (@(posedge pclk) disable iff (!presetn)
		state == adcavg_pkg::ADCAVG_ACC && acc_wr |=> state == adcavg_pkg::ADCAVG_IDLE)
		else $error("run survived control write");

	// a finished run returns to idle
	a_valid_idle: assert property (@(posedge pclk) disable iff (!presetn)
		result_valid |-> state == adcavg_pkg::ADCAVG_IDLE)
		else $error("result while accumulating");

	// result only moves with its pulse
	a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!result_valid |-> $stable(result))
		else $error("result changed without valid");

	// result read shows the stored value
	a_result_read: assert property (@(posedge pclk) disable iff (!presetn)
		rd_ok && paddr == `ADCAVG_RESULT_ADDR |-> prdata == {10'h000, result})
		else $error("result read wrong");

	// status shows protect and reserved code
	a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
		rd_ok && paddr == `ADCAVG_STATUS_ADDR |-> prdata[0] == wprot && prdata[2] == rsvd_code)
		else $error("status read wrong");

	// unmapped addresses answer with an error
	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		rd_ok && paddr != `ADCAVG_ACC_CTRL_ADDR && paddr != `ADCAVG_RESULT_ADDR
		&& paddr != `ADCAVG_STATUS_ADDR && paddr != `ADCAVG_WPROT_ADDR |-> pslverr)
		else $error("unmapped access without error");

	// the control word never answers with an error
	a_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && paddr == `ADCAVG_ACC_CTRL_ADDR |-> !pslverr)
		else $error("control access gave error");

	// an error answer carries no data
	a_err_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> prdata == 32'h0000_0000)
		else $error("error answer carried data");

	// exactly one state bit is set
	a_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot(state))
		else $error("state not one-hot");

	// two-sample run completes
	c_two_samples: cover property (@(posedge pclk) disable iff (!presetn)
		acc_ctrl == 7'h01 ##0 state == adcavg_pkg::ADCAVG_ACC ##[1:20] result_valid);

	// shifted result produced
	c_shifted: cover property (@(posedge pclk) disable iff (!presetn)
		result_valid && acc_ctrl[6:4] != 3'h0);

	// protected write attempted
	c_prot_block: cover property (@(posedge pclk) disable iff (!presetn)
		wprot && wr_ok && paddr == `ADCAVG_ACC_CTRL_ADDR);

	// longest run of 1024 samples completes
	c_full_run: cover property (@(posedge pclk) disable iff (!presetn)
		result_valid && acc_ctrl[3:0] == 4'ha);

	// run cut short by a control write
	c_run_abort: cover property (@(posedge pclk) disable iff (!presetn)
		state == adcavg_pkg::ADCAVG_ACC && acc_wr);

endmodule

// >>> adcavg_top_tb.sv
// self-checking bench of the averaging control
`timescale 1ns/1ps
`include "adcavg_cfg.svh"
module adcavg_top_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        sample_valid, result_valid;
	logic [11:0] paddr, sample_data, v;
	logic [31:0] pwdata, prdata, rd, ctrl_val;
	logic [21:0] sum, last_exp;
	logic [21:0] exp_q[$];
	int          n_errors, comparisons;

	adcavg_top i_adcavg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sample_valid), .sample_data(sample_data),
		.result_valid(result_valid));

	// 200 mhz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task tally_and_finish;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 16 && pready !== 1'b1; k++) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 16) begin
			n_errors++;
			tally_and_finish;
		end
	endtask

	// back-to-back samples of random value
	task feed(input int cnt);
		sum = '0;
		for (int i = 0; i < cnt; i++) begin
			@(posedge pclk);
			v = 12'($urandom);
			sample_valid <= 1'b1;
			sample_data <= v;
			sum = sum + 22'(v);
		end
		@(posedge pclk);
		sample_valid <= 1'b0;
	endtask

	task run(input logic [3:0] n, input logic [2:0] sh);
		int k;
		ctrl_val = 32'({sh, n});
		apb(1'b1, `ADCAVG_ACC_CTRL_ADDR, ctrl_val);
		exp_q.push_back('0);
		feed(1 << n);
		exp_q[0] = sum >> sh;
		for (k = 0; k < 8 && exp_q.size() > 0; k++) @(posedge pclk);
		check(32'(exp_q.size()), 32'h0);
		if (k == 8) begin
			n_errors++;
			tally_and_finish;
		end
		apb(1'b0, `ADCAVG_RESULT_ADDR, 32'h0);
		check(rd, 32'(last_exp)); // full 22-bit width read
	endtask

	// takes the oldest note whenever a result appears
	always @(posedge pclk) begin
		if (result_valid === 1'b1) begin
			check(32'(exp_q.size() > 0), 32'h1);
			if (exp_q.size() > 0)
				last_exp = exp_q.pop_front();
		end
	end

	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, sample_valid} = '0;
		{paddr, sample_data, pwdata} = '0;
		void'($urandom(32'hff3a2bd6));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `ADCAVG_ACC_CTRL_ADDR, 32'h0);
		check(rd, 32'(`ADCAVG_ACC_CTRL_RST));
		apb(1'b1, `ADCAVG_ACC_CTRL_ADDR, 32'hff);
		apb(1'b0, `ADCAVG_ACC_CTRL_ADDR, 32'h0);
		check(rd, 32'h7f);
		feed(8);
		repeat (4) @(posedge pclk);
		for (int n = 0; n <= 10; n++) run(4'(n), 3'($urandom_range(7)));
		apb(1'b0, 12'h020, 32'h0);
		check(32'(err), 32'h1);
		apb(1'b1, `ADCAVG_WPROT_ADDR, 32'h1);
		apb(1'b1, `ADCAVG_ACC_CTRL_ADDR, 32'h25);
		apb(1'b0, `ADCAVG_ACC_CTRL_ADDR, 32'h0);
		check(rd, ctrl_val);
		apb(1'b0, `ADCAVG_STATUS_ADDR, 32'h0);
		check(rd, 32'h1);
		tally_and_finish;
	end
endmodule
